// ### drive_trip_monitor.sv
// Drive protection monitor: alarm detection, persistence, trip latching.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - Field over-current above 120% of calibration.
// - Field over-current only in current-control mode.
// - Field over-current trips after 10 s continuous.
// - Heat-sink over-temperature trips after 0.5 s continuous.
// - Heat-sink trip refuses restart until the heat-sink cools.
// - Motor over-temperature trips after 5 s continuous.
// - Motor trip refuses restart until the motor cools.
// - Armature over-voltage above 120% of rated volts.
// - Armature over-voltage trips after 1 s continuous.
// - Speed fault when feedbacks differ beyond alarm level.
// - Speed fault on opposite signs, both above 10%.
// - Speed fault below 10% in field weakening region.
// - Speed fault trips after 0.125 s continuous.
// - Encoder loss trips at once without speed signal.
// - A condition clearing early prevents its trip.
// - Trips reported as fixed bits of a 16-bit word.
// - A new trip shows its cause code at once, unless a lower-bit trip starts in the same cycle.
module drive_trip_monitor
#(
  parameter longint unsigned FOC_CYCLES = trip_pkg::FOC_CYCLES,
  parameter longint unsigned HS_CYCLES  = trip_pkg::HS_CYCLES,
  parameter longint unsigned MOT_CYCLES = trip_pkg::MOT_CYCLES,
  parameter longint unsigned AOV_CYCLES = trip_pkg::AOV_CYCLES,
  parameter longint unsigned SPD_CYCLES = trip_pkg::SPD_CYCLES
)
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite register bus
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // Measurement front end
  input  wire trip_pkg::meas_t   meas,
  input  wire trip_pkg::status_t status,
  // Sequencer requests
  input  wire logic              trip_reset,
  input  wire logic              restart_req,
  // Sequencer and display outputs
  output logic [15:0]            active_trip_word,
  output logic [3:0]             trip_cause,
  output logic                   trip_event,
  output logic                   restart_grant,
  output logic                   restart_refused,
  output logic                   restart_inhibit,
  output logic                   irq
);

  // ========================================
  // Register bus
  localparam int NT = trip_pkg::NUM_TRIPS;
  logic [7:0]          rd_addr;
  logic [31:0]         rd_data;
  trip_pkg::reg_wr_t   reg_wr;

  ahb_slave u_bus
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .reg_wr    (reg_wr)
  );

  logic [2:0]    ctrl_q;
  logic [15:0]   field_cal_q;
  logic [15:0]   arm_rated_q;
  logic [15:0]   mismatch_alarm_level_q;
  logic [NT-1:0] irq_status_q;
  logic [NT-1:0] irq_status_d;
  logic [NT-1:0] irq_mask_q;
  logic          irq_q;
  logic          wr_ctrl;
  logic          wr_cal;
  logic          wr_rated;
  logic          wr_level;
  logic          wr_status;
  logic          wr_mask;
  logic          field_weakening_enable;
  logic [1:0]    speed_feedback_source;

  assign wr_ctrl   = reg_wr.en && (reg_wr.addr == trip_pkg::OFS_CTRL);
  assign wr_cal    = reg_wr.en && (reg_wr.addr == trip_pkg::OFS_FIELD_CAL);
  assign wr_rated  = reg_wr.en && (reg_wr.addr == trip_pkg::OFS_ARM_RATED);
  assign wr_level  = reg_wr.en && (reg_wr.addr == trip_pkg::OFS_MISMATCH);
  assign wr_status = reg_wr.en && (reg_wr.addr == trip_pkg::OFS_IRQ_STATUS);
  assign wr_mask   = reg_wr.en && (reg_wr.addr == trip_pkg::OFS_IRQ_MASK);
  assign field_weakening_enable = ctrl_q[trip_pkg::CTRL_FW_BIT];
  assign speed_feedback_source  = ctrl_q[trip_pkg::CTRL_SRC_LSB +: 2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q                 <= trip_pkg::CTRL_RESET;
      field_cal_q            <= trip_pkg::FIELD_CAL_RESET;
      arm_rated_q            <= trip_pkg::ARM_RATED_RESET;
      mismatch_alarm_level_q <= trip_pkg::MISMATCH_RESET;
      irq_mask_q             <= '0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wr.data[2:0];
      if (wr_cal)
        field_cal_q <= reg_wr.data[15:0];
      if (wr_rated)
        arm_rated_q <= reg_wr.data[15:0];
      if (wr_level)
        mismatch_alarm_level_q <= reg_wr.data[15:0];
      if (wr_mask)
        irq_mask_q <= reg_wr.data[NT-1:0];
    end
  end

  // ========================================
  // Alarm conditions
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  logic [19:0] fc_x10;
  logic [19:0] cal_x12;
  logic [19:0] av_x10;
  logic [19:0] rated_x12;
  logic [15:0] spd_mag;
  logic [15:0] arm_mag;
  logic [19:0] spd_x10;
  logic [19:0] arm_x10;
  logic [19:0] full20;
  logic signed [16:0] spd_diff;
  logic [16:0] diff_mag;
  logic        foc_cond;
  logic        aov_cond;
  logic        spd_mismatch;
  logic        spd_polarity;
  logic        spd_weak_low;
  logic        spd_cond;
  logic        enc_cond;
  logic [NT-1:0] cond;

  // Products keep full width so the 120 % test has no rounding error.
  assign fc_x10    = {4'h0, meas.field_current} * trip_pkg::OVER_DEN;
  assign cal_x12   = {4'h0, field_cal_q} * trip_pkg::OVER_NUM;
  assign av_x10    = {4'h0, meas.armature_volts} * trip_pkg::OVER_DEN;
  assign rated_x12 = {4'h0, arm_rated_q} * trip_pkg::OVER_NUM;
  assign foc_cond  = status.field_current_mode && (fc_x10 > cal_x12);
  assign aov_cond  = (av_x10 > rated_x12);

  assign spd_mag   = mag16(meas.speed_fbk);
  assign arm_mag   = mag16(meas.armature_fbk);
  assign spd_x10   = {4'h0, spd_mag} * trip_pkg::LOW_DEN;
  assign arm_x10   = {4'h0, arm_mag} * trip_pkg::LOW_DEN;
  assign full20    = {4'h0, trip_pkg::PCT_FULL};
  assign spd_diff  = {meas.speed_fbk[15], meas.speed_fbk}
                   - {meas.armature_fbk[15], meas.armature_fbk};
  assign diff_mag  = spd_diff[16] ? 17'(-spd_diff) : 17'(spd_diff);

  assign spd_mismatch = diff_mag > {1'b0, mismatch_alarm_level_q};
  assign spd_polarity = (meas.speed_fbk[15] != meas.armature_fbk[15])
                     && (spd_x10 > full20) && (arm_x10 > full20);
  assign spd_weak_low = field_weakening_enable && status.field_weak_region
                     && (spd_x10 < full20);
  assign spd_cond     = spd_mismatch || spd_polarity || spd_weak_low;

  assign enc_cond = !status.speed_signal_present
                 || ((speed_feedback_source == trip_pkg::SRC_ENCODER)
                     && !status.encoder_present);

  assign cond[trip_pkg::IDX_FOC] = foc_cond;
  assign cond[trip_pkg::IDX_HS]  = status.heatsink_hot;
  assign cond[trip_pkg::IDX_MOT] = status.motor_hot;
  assign cond[trip_pkg::IDX_AOV] = aov_cond;
  assign cond[trip_pkg::IDX_SPD] = spd_cond;
  assign cond[trip_pkg::IDX_ENC] = enc_cond;

  // ========================================
  // Persistence timers
  logic [trip_pkg::TIMER_W-1:0] limit [trip_pkg::NUM_TIMED];
  logic [NT-1:0]                set_vec;

  assign limit[trip_pkg::IDX_FOC] = 32'(FOC_CYCLES);
  assign limit[trip_pkg::IDX_HS]  = 32'(HS_CYCLES);
  assign limit[trip_pkg::IDX_MOT] = 32'(MOT_CYCLES);
  assign limit[trip_pkg::IDX_AOV] = 32'(AOV_CYCLES);
  assign limit[trip_pkg::IDX_SPD] = 32'(SPD_CYCLES);

  genvar gi;
  generate
    for (gi = 0; gi < trip_pkg::NUM_TIMED; gi++)
    begin : g_timer
      persist_timer u_timer
      (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cond    (cond[gi]),
        .limit   (limit[gi]),
        .expired (set_vec[gi])
      );
    end
  endgenerate

  // Loss of speed signal leaves nothing to wait on, so it trips at once.
  assign set_vec[trip_pkg::IDX_ENC] = enc_cond;

  // ========================================
  // Trip latches, word and cause
  logic [NT-1:0] trip_q;
  logic [NT-1:0] trip_d;
  logic [NT-1:0] new_trip;
  logic [15:0]   word_d;
  logic [15:0]   word_q;
  logic [3:0]    cause_d;
  logic [3:0]    cause_q;
  logic          event_q;

  // A new set wins over a reset arriving in the same cycle.
  generate
    for (gi = 0; gi < NT; gi++)
    begin : g_latch
      assign trip_d[gi] = set_vec[gi]
                       || (trip_q[gi] && !(trip_reset && !cond[gi]));
    end
  endgenerate

  assign new_trip = trip_d & ~trip_q;
  assign word_d   = 16'(trip_d) << trip_pkg::WORD_LSB;

  always_comb
  begin
    cause_d = cause_q;
    for (int i = NT - 1; i >= 0; i--)
    begin
      if (new_trip[i])
        cause_d = trip_pkg::CAUSE_BASE + 4'(i);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trip_q  <= '0;
      word_q  <= 16'h0000;
      cause_q <= trip_pkg::CAUSE_NONE;
      event_q <= 1'b0;
    end
    else
    begin
      trip_q  <= trip_d;
      word_q  <= word_d;
      cause_q <= cause_d;
      event_q <= |new_trip;
    end
  end

  // ========================================
  // Restart hold-off
  logic hold_off;
  logic grant_q;
  logic refused_q;
  logic inhibit_q;

  assign hold_off = (trip_q[trip_pkg::IDX_HS] && status.heatsink_hot)
                 || (trip_q[trip_pkg::IDX_MOT] && status.motor_hot);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      grant_q   <= 1'b0;
      refused_q <= 1'b0;
      inhibit_q <= 1'b0;
    end
    else
    begin
      grant_q   <= restart_req && !hold_off;
      refused_q <= restart_req && hold_off;
      inhibit_q <= hold_off;
    end
  end

  // ========================================
  // Interrupts and read-back
  // Write-one-to-clear; a trip in the clearing cycle stays recorded.
  assign irq_status_d = (irq_status_q
                         & ~({NT{wr_status}} & reg_wr.data[NT-1:0]))
                      | new_trip;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status_q <= '0;
      irq_q        <= 1'b0;
    end
    else
    begin
      irq_status_q <= irq_status_d;
      irq_q        <= |(irq_status_d & irq_mask_q);
    end
  end

  logic [31:0] rd_ctrl;
  logic [31:0] rd_cal;
  logic [31:0] rd_rated;
  logic [31:0] rd_level;
  logic [31:0] rd_word;
  logic [31:0] rd_status;
  logic [31:0] rd_mask;
  logic [31:0] rd_cause;
  logic [31:0] rd_live;

  assign rd_ctrl   = {29'h0, ctrl_q};
  assign rd_cal    = {16'h0000, field_cal_q};
  assign rd_rated  = {16'h0000, arm_rated_q};
  assign rd_level  = {16'h0000, mismatch_alarm_level_q};
  assign rd_word   = {16'h0000, word_q};
  assign rd_status = {26'h0, irq_status_q};
  assign rd_mask   = {26'h0, irq_mask_q};
  assign rd_cause  = {28'h0, cause_q};
  assign rd_live   = {26'h0, cond};

  // Unmapped addresses read as zero with an OKAY response.
  assign rd_data =
      (rd_addr == trip_pkg::OFS_CTRL)       ? rd_ctrl   :
      (rd_addr == trip_pkg::OFS_FIELD_CAL)  ? rd_cal    :
      (rd_addr == trip_pkg::OFS_ARM_RATED)  ? rd_rated  :
      (rd_addr == trip_pkg::OFS_MISMATCH)   ? rd_level  :
      (rd_addr == trip_pkg::OFS_TRIP_WORD)  ? rd_word   :
      (rd_addr == trip_pkg::OFS_IRQ_STATUS) ? rd_status :
      (rd_addr == trip_pkg::OFS_IRQ_MASK)   ? rd_mask   :
      (rd_addr == trip_pkg::OFS_CAUSE)      ? rd_cause  :
      (rd_addr == trip_pkg::OFS_LIVE)       ? rd_live   :
      32'h0000_0000;

  assign active_trip_word = word_q;
  assign trip_cause       = cause_q;
  assign trip_event       = event_q;
  assign restart_grant    = grant_q;
  assign restart_refused  = refused_q;
  assign restart_inhibit  = inhibit_q;
  assign irq              = irq_q;

endmodule

// ### trip_pkg.sv
// Shared constants, register map and carrier types of the drive trip monitor.
package trip_pkg;

  // ========================================
  // Timing
  localparam longint unsigned CLK_HZ          = 40_000_000;
  localparam longint unsigned FOC_TIME_MS     = 10000;
  localparam longint unsigned HS_TIME_MS      = 500;
  localparam longint unsigned MOT_TIME_MS     = 5000;
  localparam longint unsigned AOV_TIME_MS     = 1000;
  localparam longint unsigned SPD_TIME_MS     = 125;
  localparam longint unsigned FOC_CYCLES      = CLK_HZ * FOC_TIME_MS / 1000;
  localparam longint unsigned HS_CYCLES       = CLK_HZ * HS_TIME_MS / 1000;
  localparam longint unsigned MOT_CYCLES      = CLK_HZ * MOT_TIME_MS / 1000;
  localparam longint unsigned AOV_CYCLES      = CLK_HZ * AOV_TIME_MS / 1000;
  localparam longint unsigned SPD_CYCLES      = CLK_HZ * SPD_TIME_MS / 1000;
  localparam int              TIMER_W         = 32;

  // ========================================
  // Trip indices, word positions and cause codes
  localparam int              IDX_FOC         = 0;
  localparam int              IDX_HS          = 1;
  localparam int              IDX_MOT         = 2;
  localparam int              IDX_AOV         = 3;
  localparam int              IDX_SPD         = 4;
  localparam int              IDX_ENC         = 5;
  localparam int              NUM_TIMED       = 5;
  localparam int              NUM_TRIPS       = 6;
  localparam int              WORD_LSB        = 2;
  localparam logic [3:0]      CAUSE_BASE      = 4'h2;
  localparam logic [3:0]      CAUSE_NONE      = 4'h0;

  // ========================================
  // Scaling: 100 % of a feedback equals PCT_FULL counts
  localparam logic [15:0]     PCT_FULL        = 16'h1000;
  localparam logic [19:0]     OVER_NUM        = 20'h0_000C;
  localparam logic [19:0]     OVER_DEN        = 20'h0_000A;
  localparam logic [19:0]     LOW_DEN         = 20'h0_000A;
  localparam logic [1:0]      SRC_ENCODER     = 2'h2;

  // ========================================
  // Register map (byte addresses) and reset values
  localparam logic [7:0]      OFS_CTRL        = 8'h00;
  localparam logic [7:0]      OFS_FIELD_CAL   = 8'h04;
  localparam logic [7:0]      OFS_ARM_RATED   = 8'h08;
  localparam logic [7:0]      OFS_MISMATCH    = 8'h0C;
  localparam logic [7:0]      OFS_TRIP_WORD   = 8'h10;
  localparam logic [7:0]      OFS_IRQ_STATUS  = 8'h14;
  localparam logic [7:0]      OFS_IRQ_MASK    = 8'h18;
  localparam logic [7:0]      OFS_CAUSE       = 8'h1C;
  localparam logic [7:0]      OFS_LIVE        = 8'h20;
  localparam int              CTRL_FW_BIT     = 0;
  localparam int              CTRL_SRC_LSB    = 1;
  localparam logic [2:0]      CTRL_RESET      = 3'h0;
  localparam logic [15:0]     FIELD_CAL_RESET = 16'h1000;
  localparam logic [15:0]     ARM_RATED_RESET = 16'h1000;
  localparam logic [15:0]     MISMATCH_RESET  = 16'h0800;

  // ========================================
  // Carriers
  typedef struct packed {
    logic        [15:0] field_current;
    logic        [15:0] armature_volts;
    logic signed [15:0] speed_fbk;
    logic signed [15:0] armature_fbk;
  } meas_t;

  typedef struct packed {
    logic field_current_mode;
    logic field_weak_region;
    logic heatsink_hot;
    logic motor_hot;
    logic encoder_present;
    logic speed_signal_present;
  } status_t;

  typedef struct packed {
    logic        en;
    logic [7:0]  addr;
    logic [31:0] data;
  } reg_wr_t;

endpackage

// ### persist_timer.sv
// Persistence timer: flags expiry once its condition has held for a count.
`timescale 1ns/1ps
module persist_timer
(
  // Clock and reset
  input  wire logic                           hclk,
  input  wire logic                           hresetn,
  // Condition and terminal count
  input  wire logic                           cond,
  input  wire logic [trip_pkg::TIMER_W-1:0]   limit,
  // Result
  output logic                                expired
);

  logic [trip_pkg::TIMER_W-1:0] count_q;
  logic [trip_pkg::TIMER_W-1:0] count_d;
  logic                         expired_q;
  logic                         at_end;

  // The count saturates so a held condition cannot wrap back to zero.
  assign at_end  = (count_q >= limit - 32'h0000_0001);
  assign count_d = !cond ? '0 : (at_end ? count_q : count_q + 32'h0000_0001);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_q   <= '0;
      expired_q <= 1'b0;
    end
    else
    begin
      count_q   <= count_d;
      expired_q <= cond && at_end;
    end
  end

  assign expired = expired_q;

endmodule

// ### ahb_slave.sv
// AHB-Lite slave front end: zero-wait answers and a registered write strobe.
`timescale 1ns/1ps
module ahb_slave
(
  // AHB-Lite bus
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic          hready,
  input  wire logic [31:0]   hwdata,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // Register file side
  output logic [7:0]         rd_addr,
  input  wire logic [31:0]   rd_data,
  output trip_pkg::reg_wr_t  reg_wr
);

  logic        take;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;

  // Only whole words are mapped, so hsize is accepted but not decoded.
  assign take    = hsel && htrans[1] && hready;
  assign rd_addr = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      if (take && hwrite)
        wr_addr_q <= haddr[7:0];
      if (take && !hwrite)
        hrdata_q <= rd_data;
    end
  end

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = hrdata_q;
  assign reg_wr.en    = wr_pend_q;
  assign reg_wr.addr  = wr_addr_q;
  assign reg_wr.data  = hwdata;

endmodule

// ### front_end_model.sv
// Behavioural model of the drive measurement front end.
`timescale 1ns/1ps
module front_end_model
(
  // Measurements and flags towards the monitor
  output trip_pkg::meas_t   meas,
  output trip_pkg::status_t status
);
  // ========================================
  // Update task
  // Callers stand just after a rising edge, so updates land off the edge.
  task automatic put(input trip_pkg::meas_t m, input trip_pkg::status_t s);
    meas   <= m;
    status <= s;
  endtask
  initial
  begin
    meas   = 64'h0000_0000_0000_0000;
    status = 6'h03;
  end
endmodule

// ### drive_trip_monitor_checker.sv
// Port-level assertions for the drive trip monitor, bound to the design.
`timescale 1ns/1ps
module drive_trip_monitor_checker
#(
  parameter longint unsigned HS_CYCLES  = 8,
  parameter longint unsigned MOT_CYCLES = 12
)
(
  // Clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // Conditions and requests
  input wire trip_pkg::status_t status,
  input wire logic              trip_reset,
  input wire logic              restart_req,
  // Results
  input wire logic [15:0]       active_trip_word,
  input wire logic [3:0]        trip_cause,
  input wire logic              trip_event,
  input wire logic              restart_grant,
  input wire logic              restart_refused,
  input wire logic              restart_inhibit
);
  // ========================================
  // Uninterrupted run lengths of the temperature flags
  // No saturation: a run of 2^32 cycles is far beyond any simulation.
  logic [31:0] hs_run_q;
  logic [31:0] mot_run_q;
  wire         held_off = (active_trip_word[3] & status.heatsink_hot) |
                          (active_trip_word[4] & status.motor_hot);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hs_run_q  <= 32'h0000_0000;
      mot_run_q <= 32'h0000_0000;
    end
    else
    begin
      hs_run_q  <= status.heatsink_hot ? hs_run_q + 32'h0000_0001 : '0;
      mot_run_q <= status.motor_hot ? mot_run_q + 32'h0000_0001 : '0;
    end
  end
  // ========================================
  // Assertions
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_hs_persist:
    assert property ($rose(active_trip_word[3]) |->
      $past(hs_run_q) >= HS_CYCLES) else $error("Early heat-sink trip.");
  a_mot_persist:
    assert property ($rose(active_trip_word[4]) |->
      $past(mot_run_q) >= MOT_CYCLES) else $error("Early motor trip.");
  a_new_trip_cause:
    assert property ($rose(active_trip_word[3]) |-> trip_event &&
      (trip_cause == 4'h3 || $rose(active_trip_word[2])))
    else $error("Cause not shown.");
  a_enc_loss_trip:
    assert property (!status.speed_signal_present |=> active_trip_word[7])
    else $error("Encoder loss not tripped.");
  a_trip_held:
    assert property (!trip_reset |=>
      ($past(active_trip_word) & ~active_trip_word) == 16'h0000)
    else $error("Trip dropped without reset.");
  a_reset_refused:
    assert property (trip_reset && active_trip_word[3] &&
      status.heatsink_hot |=> active_trip_word[3])
    else $error("Hot trip cleared by reset.");
  a_restart_refused:
    assert property (restart_req && held_off && restart_inhibit |=>
      restart_refused && !restart_grant) else $error("Restart not refused.");
  a_restart_granted:
    assert property (restart_req && !held_off && !restart_inhibit |=>
      restart_grant && !restart_refused) else $error("Restart not granted.");
  c_hs_trip: cover property ($rose(active_trip_word[3]));
  c_held_off: cover property (restart_req && held_off);
  c_enc_trip: cover property ($rose(active_trip_word[7]));
endmodule
bind drive_trip_monitor drive_trip_monitor_checker #(.HS_CYCLES(HS_CYCLES),
  .MOT_CYCLES(MOT_CYCLES)) drive_trip_monitor_checker_inst (.hclk, .hresetn,
  .status, .trip_reset, .restart_req, .active_trip_word, .trip_cause,
  .trip_event, .restart_grant, .restart_refused, .restart_inhibit);

// ### drive_trip_monitor_tb.sv
// Self-checking bench for the drive trip monitor.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module drive_trip_monitor_tb;
  typedef struct packed {trip_pkg::meas_t m; trip_pkg::status_t s;
    logic [2:0] ctrl; logic [3:0] b; logic [7:0] lim;} case_t;
  logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
  logic              hwrite = 1'b0, trip_reset = 1'b0, restart_req = 1'b0;
  logic              rd_pend = 1'b0, hready, hreadyout, hresp, irq;
  logic              trip_event, restart_grant, restart_refused;
  logic              restart_inhibit;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic [3:0]        trip_cause, last_cause = 4'h0;
  logic [15:0]       active_trip_word;
  logic [31:0]       haddr = '0, hwdata = '0, hrdata, exp_v;
  logic [31:0]       exp_q[$];
  trip_pkg::meas_t   meas;
  trip_pkg::status_t status;
  int                fail_count = 0, checked = 0;
  localparam logic [7:0] ADDRS [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
    8'h14, 8'h18, 8'h1C, 8'h40};
  localparam logic [31:0] RSTV [9] = '{32'h0000_0000, 32'h0000_1000,
    32'h0000_1000, 32'h0000_0800, '0, '0, '0, '0, '0};
  localparam case_t CASES [11] = '{
    '{64'h1334_0000_0000_0000, 6'h23, 3'h0, 4'h2, 8'h14},
    '{64'h1334_0000_0000_0000, 6'h03, 3'h0, 4'h0, 8'h19},
    '{64'h0000_0000_0000_0000, 6'h0B, 3'h0, 4'h3, 8'h08},
    '{64'h0000_0000_0000_0000, 6'h07, 3'h0, 4'h4, 8'h0C},
    '{64'h0000_1334_0000_0000, 6'h03, 3'h0, 4'h5, 8'h0A},
    '{64'h0000_1333_0000_0000, 6'h03, 3'h0, 4'h0, 8'h19},
    '{64'h0000_0000_0900_0000, 6'h03, 3'h0, 4'h6, 8'h06},
    '{64'h0000_0000_0200_FE00, 6'h03, 3'h0, 4'h6, 8'h06},
    '{64'h0000_0000_0100_0100, 6'h13, 3'h1, 4'h6, 8'h06},
    '{64'h0000_0000_0000_0000, 6'h02, 3'h0, 4'h7, 8'h00},
    '{64'h0000_0000_0000_0000, 6'h01, 3'h4, 4'h7, 8'h00}};
  drive_trip_monitor #(.FOC_CYCLES(20), .HS_CYCLES(8), .MOT_CYCLES(12),
    .AOV_CYCLES(10), .SPD_CYCLES(6)) drive_trip_monitor_inst (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .hreadyout, .hresp, .hrdata, .meas, .status, .trip_reset, .restart_req,
    .active_trip_word, .trip_cause, .trip_event, .restart_grant,
    .restart_refused, .restart_inhibit, .irq);
  front_end_model front_end_model_inst (.meas, .status);
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  // ========================================
  // Bus master, result monitor and closing
  task automatic xfer(input logic [7:0] a, logic w, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= !w;
    if (!w)
      exp_q.push_back(d);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_pend <= 1'b0;
  endtask
  always @(posedge hclk)
  begin
    if (rd_pend && hreadyout)
    begin
      exp_v = exp_q.pop_front();
      `CHK("hrdata", exp_v, hrdata)
      `CHK("hresp", 1'b0, hresp)
    end
  end
  task automatic close_out();
    if ((fail_count == 0) && (checked > 0))
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Benign levels: random magnitudes kept just under the trip thresholds.
  task automatic put_base();
    logic [15:0] f, v;
    f = 16'($urandom_range(16'h1332));
    v = 16'($urandom_range(16'h1332));
    front_end_model_inst.put({f, v, 32'h0000_0000}, 6'h03);
  endtask
  // ========================================
  // One alarm case: glitch, full trip, restart, reset, interrupt
  task automatic run_case(input case_t c, input logic [5:0] mask);
    logic        hold;
    logic [31:0] w;
    hold = (c.b == 4'h3) || (c.b == 4'h4);
    w = (c.b != 4'h0) ? 32'h0000_0001 << c.b : 32'h0000_0000;
    if (c.b != 4'h0)
      last_cause = c.b;
    xfer(trip_pkg::OFS_CTRL, 1'b1, {29'h0000_0000, c.ctrl});
    xfer(trip_pkg::OFS_IRQ_MASK, 1'b1, {26'h000_0000, mask});
    xfer(trip_pkg::OFS_IRQ_MASK, 1'b0, {26'h000_0000, mask});
    if (c.lim > 8'h01)
    begin
      front_end_model_inst.put(c.m, c.s);
      repeat (1 + $urandom % (c.lim - 8'h01)) @(posedge hclk);
      put_base();
      xfer(trip_pkg::OFS_TRIP_WORD, 1'b0, 32'h0000_0000);
    end
    front_end_model_inst.put(c.m, c.s);
    repeat (c.lim + 3) @(posedge hclk);
    xfer(trip_pkg::OFS_TRIP_WORD, 1'b0, w);
    xfer(trip_pkg::OFS_CAUSE, 1'b0, {28'h000_0000, last_cause});
    restart_req <= 1'b1;
    @(posedge hclk);
    restart_req <= 1'b0;
    @(negedge hclk);
    `CHK("restart_refused", hold, restart_refused)
    `CHK("restart_grant", !hold, restart_grant)
    `CHK("restart_inhibit", hold, restart_inhibit)
    `CHK("irq", (c.b != 4'h0) && (mask != 6'h00), irq)
    @(posedge hclk);
    trip_reset <= 1'b1;
    @(posedge hclk);
    trip_reset <= 1'b0;
    xfer(trip_pkg::OFS_TRIP_WORD, 1'b0, w);
    put_base();
    repeat (3) @(posedge hclk);
    trip_reset <= 1'b1;
    @(posedge hclk);
    trip_reset <= 1'b0;
    xfer(trip_pkg::OFS_TRIP_WORD, 1'b0, 32'h0000_0000);
    xfer(trip_pkg::OFS_IRQ_STATUS, 1'b0, w >> 2);
    xfer(trip_pkg::OFS_IRQ_STATUS, 1'b1, 32'h0000_003F);
    xfer(trip_pkg::OFS_IRQ_STATUS, 1'b0, 32'h0000_0000);
    @(negedge hclk);
    `CHK("irq", 1'b0, irq)
    @(posedge hclk);
  endtask
  initial
  begin
    void'($urandom(58824));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    put_base();
    @(posedge hclk);
    xfer(trip_pkg::OFS_TRIP_WORD, 1'b1, 32'hFFFF_FFFF);
    xfer(8'h40, 1'b1, $urandom());
    foreach (ADDRS[i])
      xfer(ADDRS[i], 1'b0, RSTV[i]);
    foreach (CASES[i])
      run_case(CASES[i], (i % 2) ? 6'h00 : 6'h3F);
    close_out();
  end
  initial
  begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    close_out();
  end
endmodule
